// >>> srs_regs.sv
`timescale 1ns/1ps

// Behaviour
// - Only status and command words accept writes
// - Sleep code to command enters sleep
// - Reset code restarts and reloads configuration
// - Command word sixteen bits, write-only, zero
// - Temperature result read-only, load sets flag
// - Pressure result read-only, load sets flag
// - Results invalid until first measurement loaded
// - Failed configuration check blocks result updates
// - Snapshot mirrors live bits fifteen-five, zero
// - Snapshot bits four, three captured on read
// - Three-word read burst from temperature address
// - Status bit zero shows idle
// - Update flags set on load, clear on read
// - Bridge supply and check failure events
// - Saturation condition bit ten follows source
// - Missed bits when update flag still set
// - Events cleared by writing one, live only
// - All ones clears every event
// - Condition bits follow hardware source
// - Frame checksum failure sets bit eleven
// - Word aligned accesses, low byte first
module srs_regs
  import srs_pkg::*;
(
  input  wire logic               clk,
  input  wire logic               rst_b,
  input  wire logic               linkClk,
  input  wire logic               linkReq,
  input  wire logic               linkWrite,
  input  wire logic [srs_pkg::AW-1:0] linkAddr,
  input  wire logic [srs_pkg::DW-1:0] linkWdata,
  input  wire logic               linkCrcErr,
  output logic                    linkBusy,
  output logic                    linkAck,
  output logic [srs_pkg::DW-1:0]  linkRdata,
  input  wire logic               tempLoad,
  input  wire logic [srs_pkg::DW-1:0] tempIn,
  input  wire logic               pressLoad,
  input  wire logic [srs_pkg::DW-1:0] pressIn,
  input  wire logic               satIn,
  input  wire logic               busyIn,
  input  wire logic               bridgeSupplyFailure,
  input  wire logic               bridgeCheckFailure,
  input  wire logic               cfgCrcFail,
  output logic                    sleepMode,
  output logic                    softResetReq
);
  import srs_pkg::*;

  // ************************************************************
  // Reset release, one copy per clock domain
  // ************************************************************
  logic            rstMeta_r;
  logic            rstN_r;
  logic            lrstMeta_r;
  logic            lrstN_r;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rstMeta_r <= 1'b0;
      rstN_r    <= 1'b0;
    end else begin
      rstMeta_r <= 1'b1;
      rstN_r    <= rstMeta_r;
    end
  end

  always_ff @(posedge linkClk or negedge rst_b) begin
    if (!rst_b) begin
      lrstMeta_r <= 1'b0;
      lrstN_r    <= 1'b0;
    end else begin
      lrstMeta_r <= 1'b1;
      lrstN_r    <= lrstMeta_r;
    end
  end

  // ************************************************************
  // Link side: one word access in flight at a time
  // ************************************************************
  logic [AW-1:0]   holdAddr_r;
  logic            holdWrite_r;
  logic [DW-1:0]   holdWdata_r;
  logic            reqTog_r;
  logic            crcTog_r;
  logic            ackSync1_r;
  logic            ackSync2_r;
  logic            ackSync3_r;
  logic            linkBusy_r;
  logic            linkAck_r;
  logic [DW-1:0]   linkRdata_r;
  logic            ackTog_r;
  logic [DW-1:0]   rdHold_r;
  logic            ackNew;
  logic            reqTake;

  assign reqTake = linkReq & ~linkBusy_r;
  assign ackNew  = ackSync2_r ^ ackSync3_r;

  // Hold words stay still while the toggle crosses, so no word sync needed
  always_ff @(posedge linkClk or negedge lrstN_r) begin
    if (!lrstN_r) begin
      holdAddr_r  <= '0;
      holdWrite_r <= 1'b0;
      holdWdata_r <= '0;
      reqTog_r    <= 1'b0;
    end else if (reqTake) begin
      holdAddr_r  <= linkAddr;
      holdWrite_r <= linkWrite;
      holdWdata_r <= linkWdata;
      reqTog_r    <= ~reqTog_r;
    end
  end

  always_ff @(posedge linkClk or negedge lrstN_r) begin
    if (!lrstN_r) begin
      crcTog_r <= 1'b0;
    end else if (linkCrcErr) begin
      crcTog_r <= ~crcTog_r;
    end
  end

  always_ff @(posedge linkClk or negedge lrstN_r) begin
    if (!lrstN_r) begin
      ackSync1_r  <= 1'b0;
      ackSync2_r  <= 1'b0;
      ackSync3_r  <= 1'b0;
      linkBusy_r  <= 1'b0;
      linkAck_r   <= 1'b0;
      linkRdata_r <= '0;
    end else begin
      ackSync1_r <= ackTog_r;
      ackSync2_r <= ackSync1_r;
      ackSync3_r <= ackSync2_r;
      linkAck_r  <= ackNew;
      if (ackNew) begin
        linkBusy_r  <= 1'b0;
        linkRdata_r <= rdHold_r;
      end else if (reqTake) begin
        linkBusy_r  <= 1'b1;
      end
    end
  end

  assign linkBusy  = linkBusy_r;
  assign linkAck   = linkAck_r;
  assign linkRdata = linkRdata_r;

  // ************************************************************
  // Core side: access decode
  // ************************************************************
  logic            reqSync1_r;
  logic            reqSync2_r;
  logic            reqSync3_r;
  logic            crcSync1_r;
  logic            crcSync2_r;
  logic            crcSync3_r;
  logic            reqNew;
  logic            crcEvt;
  logic            aligned;
  logic            accRead;
  logic            accWrite;
  logic            rdTemp;
  logic            rdPress;
  logic            wrStatus;
  logic            wrCmd;
  logic            cmdSleep;
  logic            cmdReset;

  always_ff @(posedge clk or negedge rstN_r) begin
    if (!rstN_r) begin
      reqSync1_r <= 1'b0;
      reqSync2_r <= 1'b0;
      reqSync3_r <= 1'b0;
      crcSync1_r <= 1'b0;
      crcSync2_r <= 1'b0;
      crcSync3_r <= 1'b0;
    end else begin
      reqSync1_r <= reqTog_r;
      reqSync2_r <= reqSync1_r;
      reqSync3_r <= reqSync2_r;
      crcSync1_r <= crcTog_r;
      crcSync2_r <= crcSync1_r;
      crcSync3_r <= crcSync2_r;
    end
  end

  assign reqNew   = reqSync2_r ^ reqSync3_r;
  assign crcEvt   = crcSync2_r ^ crcSync3_r;
  assign aligned  = ~holdAddr_r[0];
  assign accRead  = reqNew & ~holdWrite_r & aligned;
  assign accWrite = reqNew & holdWrite_r & aligned;
  assign rdTemp   = accRead & (holdAddr_r == ADDR_TEMP);
  assign rdPress  = accRead & (holdAddr_r == ADDR_PRESS);
  // Every other address is write protected
  assign wrStatus = accWrite & (holdAddr_r == ADDR_STATUS);
  assign wrCmd    = accWrite & (holdAddr_r == ADDR_CMD);
  assign cmdSleep = wrCmd & (holdWdata_r == CMD_SLEEP);
  assign cmdReset = wrCmd & (holdWdata_r == CMD_RESET);

  // ************************************************************
  // Results
  // ************************************************************
  logic [DW-1:0]   tempRes_r;
  logic [DW-1:0]   pressRes_r;
  logic            tempOk;
  logic            pressOk;

  assign tempOk  = tempLoad & ~cfgCrcFail;
  assign pressOk = pressLoad & ~cfgCrcFail;

  // Contents mean nothing until the first load; host polls the flags
  always_ff @(posedge clk or negedge rstN_r) begin
    if (!rstN_r) begin
      tempRes_r  <= RESET_WORD;
      pressRes_r <= RESET_WORD;
    end else begin
      if (tempOk) begin
        tempRes_r <= tempIn;
      end
      if (pressOk) begin
        pressRes_r <= pressIn;
      end
    end
  end

  // ************************************************************
  // Status flags
  // ************************************************************
  logic [DW-1:0]   event_r;
  logic [DW-1:0]   event_nxt;
  logic [DW-1:0]   evSet;
  logic [DW-1:0]   evClr;
  logic [DW-1:0]   cond_r;
  logic [1:0]      syncUp_r;
  logic [DW-1:0]   liveStatus;
  logic [DW-1:0]   syncStatus;

  always_comb begin
    evSet = '0;
    evSet[BIT_PRESS_UP]  = pressOk;
    evSet[BIT_TEMP_UP]   = tempOk;
    evSet[BIT_BRIDGE_SUPPLY_FAILURE]   = bridgeSupplyFailure;
    evSet[BIT_BRIDGE_CHECK_FAILURE]   = bridgeCheckFailure;
    evSet[BIT_CRC_ERR]   = crcEvt;
    evSet[BIT_PRESS_MIS] = pressOk & event_r[BIT_PRESS_UP];
    evSet[BIT_TEMP_MIS]  = tempOk & event_r[BIT_TEMP_UP];
    evClr = wrStatus ? holdWdata_r : '0;
    evClr[BIT_PRESS_UP] = evClr[BIT_PRESS_UP] | rdPress;
    evClr[BIT_TEMP_UP]  = evClr[BIT_TEMP_UP] | rdTemp;
    // Set wins over a clear in the same cycle
    event_nxt = ((event_r & ~evClr) | evSet) & EVENT_MASK;
  end

  always_ff @(posedge clk or negedge rstN_r) begin
    if (!rstN_r) begin
      event_r <= RESET_WORD;
    end else if (cmdReset) begin
      event_r <= RESET_WORD;
    end else begin
      event_r <= event_nxt;
    end
  end

  always_ff @(posedge clk or negedge rstN_r) begin
    if (!rstN_r) begin
      cond_r <= RESET_WORD;
    end else begin
      cond_r              <= RESET_WORD;
      cond_r[BIT_IDLE]    <= ~busyIn;
      cond_r[BIT_SAT]     <= satIn;
    end
  end

  // Snapshot takes the flag as it was before the read clears it
  always_ff @(posedge clk or negedge rstN_r) begin
    if (!rstN_r) begin
      syncUp_r <= 2'b00;
    end else if (cmdReset) begin
      syncUp_r <= 2'b00;
    end else begin
      if (rdTemp) begin
        syncUp_r[1] <= event_r[BIT_TEMP_UP];
      end
      if (rdPress) begin
        syncUp_r[0] <= event_r[BIT_PRESS_UP];
      end
    end
  end

  assign liveStatus = event_r | (cond_r & COND_MASK);
  assign syncStatus = {liveStatus[15:5], syncUp_r, 2'b00, liveStatus[0]};

  // ************************************************************
  // Read data and answer
  // ************************************************************
  always_ff @(posedge clk or negedge rstN_r) begin
    if (!rstN_r) begin
      rdHold_r <= RESET_WORD;
      ackTog_r <= 1'b0;
    end else if (reqNew) begin
      ackTog_r <= ~ackTog_r;
      if (accRead) begin
        // Burst from the temperature address is three single reads
        case (holdAddr_r)
          ADDR_TEMP:   rdHold_r <= tempRes_r;
          ADDR_PRESS:  rdHold_r <= pressRes_r;
          ADDR_SYNC:   rdHold_r <= syncStatus;
          ADDR_STATUS: rdHold_r <= liveStatus;
          default:     rdHold_r <= RESET_WORD;
        endcase
      end else begin
        rdHold_r <= RESET_WORD;
      end
    end
  end

  // ************************************************************
  // Power state commands
  // ************************************************************
  logic            sleepMode_r;
  logic            softReset_r;

  always_ff @(posedge clk or negedge rstN_r) begin
    if (!rstN_r) begin
      sleepMode_r <= 1'b0;
      softReset_r <= 1'b0;
    end else begin
      softReset_r <= cmdReset;
      if (cmdReset) begin
        sleepMode_r <= 1'b0;
      end else if (cmdSleep) begin
        sleepMode_r <= 1'b1;
      end
    end
  end

  assign sleepMode    = sleepMode_r;
  assign softResetReq = softReset_r;

  // ************************************************************
  // Checks
  // ************************************************************
  property p_sleep;
    @(posedge clk) disable iff (!rstN_r)
      cmdSleep |=> sleepMode_r;
  endproperty
  a_sleep: assert property (p_sleep) else $error("sleep code ignored");

  property p_reset;
    @(posedge clk) disable iff (!rstN_r)
      cmdReset |=> softReset_r && event_r == '0 ##1 !softReset_r;
  endproperty
  a_reset: assert property (p_reset) else $error("reset code pulse wrong");

  property p_tempLoad;
    @(posedge clk) disable iff (!rstN_r)
      tempOk && !cmdReset |=> tempRes_r == $past(tempIn) && event_r[BIT_TEMP_UP];
  endproperty
  a_tempLoad: assert property (p_tempLoad) else $error("temperature load lost");

  property p_crcBlock;
    @(posedge clk) disable iff (!rstN_r)
      cfgCrcFail |=> $stable(tempRes_r) && $stable(pressRes_r);
  endproperty
  a_crcBlock: assert property (p_crcBlock) else $error("result changed on bad config");

  property p_snap;
    @(posedge clk) disable iff (!rstN_r)
      rdPress && !cmdReset |=> syncUp_r[0] == $past(event_r[BIT_PRESS_UP]);
  endproperty
  a_snap: assert property (p_snap) else $error("pressure snapshot wrong");

  property p_idle;
    @(posedge clk) disable iff (!rstN_r)
      rstN_r && !busyIn ##1 !busyIn |-> liveStatus[BIT_IDLE] && syncStatus[BIT_IDLE];
  endproperty
  a_idle: assert property (p_idle) else $error("idle bit wrong");

  property p_readClr;
    @(posedge clk) disable iff (!rstN_r)
      rdPress && !pressOk |=> !event_r[BIT_PRESS_UP];
  endproperty
  a_readClr: assert property (p_readClr) else $error("pressure flag not cleared");

  property p_missed;
    @(posedge clk) disable iff (!rstN_r)
      tempOk && event_r[BIT_TEMP_UP] && !cmdReset |=> event_r[BIT_TEMP_MIS];
  endproperty
  a_missed: assert property (p_missed) else $error("missed flag not set");

  property p_sticky;
    @(posedge clk) disable iff (!rstN_r)
      event_r[BIT_BRIDGE_SUPPLY_FAILURE] && !cmdReset && !(wrStatus && holdWdata_r[BIT_BRIDGE_SUPPLY_FAILURE])
      |=> event_r[BIT_BRIDGE_SUPPLY_FAILURE];
  endproperty
  a_sticky: assert property (p_sticky) else $error("event dropped");

  property p_clearAll;
    @(posedge clk) disable iff (!rstN_r)
      wrStatus && holdWdata_r == ALL_ONES && evSet == '0 |=> event_r == '0;
  endproperty
  a_clearAll: assert property (p_clearAll) else $error("all-ones write left events");

  property p_linkAns;
    @(posedge linkClk) disable iff (!lrstN_r)
      reqTake |=> linkBusy_r ##[1:8] linkAck_r;
  endproperty
  a_linkAns: assert property (p_linkAns) else $error("link access not answered");

endmodule : srs_regs

// >>> srs_pkg.sv
package srs_pkg;

  // ************************************************************
  // Register map and field layout
  // ************************************************************
  localparam int unsigned  AW            = 8;
  localparam int unsigned  DW            = 16;
  localparam logic [7:0]   ADDR_CMD      = 8'h22;
  localparam logic [7:0]   ADDR_TEMP     = 8'h2E;
  localparam logic [7:0]   ADDR_PRESS    = 8'h30;
  localparam logic [7:0]   ADDR_SYNC     = 8'h32;
  localparam logic [7:0]   ADDR_STATUS   = 8'h36;

  localparam logic [15:0]  CMD_SLEEP     = 16'h6C32;
  localparam logic [15:0]  CMD_RESET     = 16'hB169;
  localparam logic [15:0]  ALL_ONES      = 16'hFFFF;
  localparam logic [15:0]  RESET_WORD    = 16'h0000;

  localparam int unsigned  BIT_IDLE      = 0;
  localparam int unsigned  BIT_PRESS_UP  = 3;
  localparam int unsigned  BIT_TEMP_UP   = 4;
  localparam int unsigned  BIT_BRIDGE_SUPPLY_FAILURE   = 7;
  localparam int unsigned  BIT_BRIDGE_CHECK_FAILURE   = 8;
  localparam int unsigned  BIT_SAT       = 10;
  localparam int unsigned  BIT_CRC_ERR   = 11;
  localparam int unsigned  BIT_PRESS_MIS = 14;
  localparam int unsigned  BIT_TEMP_MIS  = 15;

  // Implemented event and condition positions; all others read zero
  localparam logic [15:0]  EVENT_MASK    = 16'hC998;
  localparam logic [15:0]  COND_MASK     = 16'h0401;

endpackage : srs_pkg

// >>> srs_host_model.sv
`timescale 1ns/1ps

// ************************************************************
// Host side of the register link
// ************************************************************
module srs_host_model
  import srs_pkg::*;
(
  input  wire logic                   linkClk,
  input  wire logic                   linkBusy,
  input  wire logic                   linkAck,
  input  wire logic [srs_pkg::DW-1:0] linkRdata,
  output logic                        linkReq,
  output logic                        linkWrite,
  output logic [srs_pkg::AW-1:0]      linkAddr,
  output logic [srs_pkg::DW-1:0]      linkWdata,
  output logic                        linkCrcErr
);
  initial begin
    linkReq = 1'b0;
    linkWrite = 1'b0;
    linkAddr = 8'h00;
    linkWdata = 16'h0000;
    linkCrcErr = 1'b0;
  end

  // Whole words only, one access at a time
  task automatic access(input logic wr, input logic [7:0] a, input logic [15:0] d,
                        output logic [15:0] q, output logic ok);
    logic sawBusy;
    ok = 1'b0;
    q = 16'h0000;
    sawBusy = 1'b0;
    @(posedge linkClk);
    linkReq <= 1'b1;
    linkWrite <= wr;
    linkAddr <= a;
    linkWdata <= d;
    @(posedge linkClk);
    linkReq <= 1'b0;
    for (int i = 0; i < 12 && !ok; i++) begin
      @(posedge linkClk);
      if (linkBusy === 1'b1) begin
        sawBusy = 1'b1;
      end
      // Busy must have shown and must drop with the answer
      if (linkAck === 1'b1 && linkBusy === 1'b0) begin
        ok = 1'b1;
        q = linkRdata;
      end
    end
    ok = ok & sawBusy;
    // Released lines carry junk so stale values cannot pass for good ones
    linkAddr <= ~a;
    linkWdata <= ~d;
  endtask : access

  // Polling read of results and snapshot in one go
  task automatic burst(output logic [15:0] q [3], output logic ok);
    logic okw;
    ok = 1'b1;
    for (int i = 0; i < 3; i++) begin
      access(1'b0, ADDR_TEMP + 8'(2 * i), 16'h0000, q[i], okw);
      ok = ok & okw;
    end
  endtask : burst

  task automatic crc_err();
    @(posedge linkClk);
    linkCrcErr <= 1'b1;
    @(posedge linkClk);
    linkCrcErr <= 1'b0;
  endtask : crc_err
endmodule : srs_host_model

// >>> tb_top.sv
`timescale 1ns/1ps

module tb_top;
  import srs_pkg::*;
  logic        clk, linkClk, rst_b, tempLoad, pressLoad, satIn, busyIn;
  logic        bsf, bcf, cfgCrcFail, linkReq, linkWrite, linkCrcErr;
  logic        linkBusy, linkAck, sleepMode, softResetReq;
  logic [7:0]  linkAddr;
  logic [15:0] linkWdata, linkRdata, tempIn, pressIn;
  int          fails, nCompared, resets;

  srs_regs dut_u (.clk(clk), .rst_b(rst_b), .linkClk(linkClk), .linkReq(linkReq),
    .linkWrite(linkWrite), .linkAddr(linkAddr), .linkWdata(linkWdata),
    .linkCrcErr(linkCrcErr), .linkBusy(linkBusy), .linkAck(linkAck),
    .linkRdata(linkRdata), .tempLoad(tempLoad), .tempIn(tempIn), .pressLoad(pressLoad),
    .pressIn(pressIn), .satIn(satIn), .busyIn(busyIn), .bridgeSupplyFailure(bsf),
    .bridgeCheckFailure(bcf), .cfgCrcFail(cfgCrcFail), .sleepMode(sleepMode),
    .softResetReq(softResetReq));

  srs_host_model host_u (.linkClk(linkClk), .linkBusy(linkBusy), .linkAck(linkAck),
    .linkRdata(linkRdata), .linkReq(linkReq), .linkWrite(linkWrite),
    .linkAddr(linkAddr), .linkWdata(linkWdata), .linkCrcErr(linkCrcErr));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // Unrelated phase to the core clock
  initial begin
    linkClk = 1'b0;
    #7;
    forever #62.5 linkClk = ~linkClk;
  end
  always @(posedge clk) if (softResetReq === 1'b1) resets++;

  // ************************************************************
  // Helpers
  // ************************************************************
  task automatic stop_test();
    if (fails == 0 && nCompared > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : stop_test

  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string m);
    nCompared++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t: %s got %h exp %h", $time, m, got, exp);
    end
  endtask : chk

  task automatic xfer(input logic wr, input logic [7:0] a, input logic [15:0] d,
                      output logic [15:0] q);
    logic ok;
    host_u.access(wr, a, d, q, ok);
    if (ok !== 1'b1) begin
      fails++;
      $display("unexpected at %0t: no acknowledge", $time);
      stop_test();
    end
  endtask : xfer

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    logic [15:0] q;
    xfer(1'b1, a, d, q);
  endtask : wr

  task automatic rdchk(input logic [7:0] a, input logic [15:0] exp, input string m);
    logic [15:0] q;
    xfer(1'b0, a, 16'h0000, q);
    chk(q, exp, m);
  endtask : rdchk

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask : cyc

  task automatic ld(input logic p, input logic [15:0] v);
    @(posedge clk);
    if (p) begin
      pressLoad <= 1'b1;
      pressIn <= v;
    end else begin
      tempLoad <= 1'b1;
      tempIn <= v;
    end
    @(posedge clk);
    pressLoad <= 1'b0;
    tempLoad <= 1'b0;
  endtask : ld

  // ************************************************************
  // Scenarios
  // ************************************************************
  task automatic t_reset();
    rdchk(ADDR_STATUS, 16'h0001, "status");
    rdchk(ADDR_SYNC, 16'h0001, "snapshot");
    rdchk(ADDR_CMD, RESET_WORD, "command");
    rdchk(ADDR_TEMP, 16'h0000, "temperature");
  endtask : t_reset

  task automatic t_results();
    logic [15:0] q, b [3];
    logic        ok;
    ld(1'b0, 16'h7DF2);
    ld(1'b1, 16'h82EA);
    q = 16'h0000;
    for (int i = 0; i < 10 && q[4:3] !== 2'b11; i++) xfer(1'b0, ADDR_STATUS, 16'h0000, q);
    chk(q, 16'h0019, "update flags");
    host_u.burst(b, ok);
    chk({15'h0000, ok}, 16'h0001, "burst");
    chk(b[0], 16'h7DF2, "temperature");
    chk(b[1], 16'h82EA, "pressure");
    chk(b[2], 16'h0019, "snapshot");
    rdchk(ADDR_STATUS, 16'h0001, "after read");
    host_u.burst(b, ok);
    chk(b[2], 16'h0001, "snapshot again");
  endtask : t_results

  task automatic t_missed();
    ld(1'b0, 16'h1111);
    ld(1'b0, 16'h2222);
    ld(1'b1, 16'h3333);
    ld(1'b1, 16'h4444);
    cyc(4);
    rdchk(ADDR_STATUS, 16'hC019, "missed");
    wr(ADDR_STATUS, 16'h8000);
    rdchk(ADDR_STATUS, 16'h4019, "one clear");
    wr(ADDR_SYNC, ALL_ONES);
    rdchk(ADDR_STATUS, 16'h4019, "sync write");
    wr(ADDR_STATUS, ALL_ONES);
    rdchk(ADDR_STATUS, 16'h0001, "all clear");
    rdchk(ADDR_TEMP, 16'h2222, "latest");
  endtask : t_missed

  task automatic t_events();
    @(posedge clk);
    bsf <= 1'b1;
    bcf <= 1'b1;
    @(posedge clk);
    bsf <= 1'b0;
    bcf <= 1'b0;
    host_u.crc_err();
    cyc(4);
    rdchk(ADDR_STATUS, 16'h0981, "events");
    rdchk(ADDR_SYNC, 16'h0981, "mirror");
    wr(ADDR_STATUS, 16'h0100);
    rdchk(ADDR_STATUS, 16'h0881, "partial");
    wr(ADDR_STATUS, ALL_ONES);
  endtask : t_events

  task automatic t_cond();
    @(posedge clk);
    satIn <= 1'b1;
    busyIn <= 1'b1;
    cyc(4);
    rdchk(ADDR_STATUS, 16'h0400, "busy sat");
    @(posedge clk);
    satIn <= 1'b0;
    busyIn <= 1'b0;
    cyc(4);
    rdchk(ADDR_STATUS, 16'h0001, "idle");
  endtask : t_cond

  task automatic t_protect();
    wr(ADDR_TEMP, 16'h1234);
    wr(ADDR_PRESS, 16'h1234);
    wr(ADDR_STATUS, 16'h0266);
    rdchk(ADDR_TEMP, 16'h2222, "temp prot");
    rdchk(ADDR_PRESS, 16'h4444, "press prot");
    rdchk(ADDR_STATUS, 16'h0001, "reserved");
    rdchk(8'h2F, 16'h0000, "odd address");
    rdchk(8'h40, 16'h0000, "unmapped");
    @(posedge clk);
    cfgCrcFail <= 1'b1;
    ld(1'b0, 16'h5555);
    cyc(4);
    rdchk(ADDR_TEMP, 16'h2222, "blocked");
    rdchk(ADDR_STATUS, 16'h0001, "no flag");
    @(posedge clk);
    cfgCrcFail <= 1'b0;
  endtask : t_protect

  task automatic t_cmd();
    resets = 0;
    wr(ADDR_CMD, 16'h1234);
    cyc(3);
    chk({15'h0000, sleepMode}, 16'h0000, "other code");
    wr(ADDR_CMD, CMD_SLEEP);
    cyc(3);
    chk({15'h0000, sleepMode}, 16'h0001, "sleep");
    @(posedge clk);
    bsf <= 1'b1;
    @(posedge clk);
    bsf <= 1'b0;
    wr(ADDR_CMD, CMD_RESET);
    cyc(6);
    chk(16'(resets), 16'h0001, "restart pulse");
    chk({15'h0000, sleepMode}, 16'h0000, "wake");
    rdchk(ADDR_STATUS, 16'h0001, "restart status");
  endtask : t_cmd

  initial begin
    rst_b = 1'b0;
    tempLoad = 1'b0;
    pressLoad = 1'b0;
    tempIn = 16'h0000;
    pressIn = 16'h0000;
    satIn = 1'b0;
    busyIn = 1'b0;
    bsf = 1'b0;
    bcf = 1'b0;
    cfgCrcFail = 1'b0;
    fails = 0;
    nCompared = 0;
    resets = 0;
    repeat (20) @(posedge clk);
    rst_b <= 1'b1;
    repeat (3) @(posedge linkClk);
    t_reset();
    t_results();
    t_missed();
    t_events();
    t_cond();
    t_protect();
    t_cmd();
    stop_test();
  end
endmodule : tb_top
